// >>> design/fpl_pkg.sv
// shared constants and types for the front panel status led logic
package fpl_pkg;

  // clock and blink timing
  localparam int unsigned CLK_KHZ        = 100000;   // 100 MHz
  localparam int unsigned BLINK_HALF_MS  = 500;      // ~1 Hz, 50 % duty
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned IDENT_S        = 15;       // timed identify blink
  // the timed identify is counted in blink half periods
  localparam logic [5:0]  IDENT_TOGGLES  =
    6'(IDENT_S * 1000 / BLINK_HALF_MS);

  // correctable memory error limit
  localparam logic [3:0]  CE_LIMIT       = 4'ha;
  localparam logic [3:0]  CE_MAX         = 4'hf;

  // health input widths
  localparam int unsigned DEG_W          = 7;
  localparam int unsigned NONC_W         = 3;
  localparam int unsigned FATAL_W        = 8;

  // register bus
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_MEM       = 8'h04;
  localparam logic [7:0]  ADDR_IDENT     = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0c;

  // control register fields
  localparam int unsigned CTRL_READY_BIT  = 0;
  localparam int unsigned CTRL_SPARE_BIT  = 1;
  localparam int unsigned CTRL_MIRROR_BIT = 2;
  // memory event register fields
  localparam int unsigned MEM_CE_BIT      = 0;
  localparam int unsigned MEM_RESTART_BIT = 1;
  localparam int unsigned MEM_SPARE_BIT   = 2;
  localparam int unsigned MEM_CNT_LSB     = 4;
  // identify command register fields
  localparam int unsigned ID_TIMED_BIT    = 0;
  localparam int unsigned ID_FOREVER_BIT  = 1;
  localparam int unsigned ID_OFF_BIT      = 2;

  // top level mode
  typedef enum logic [1:0] {
    MODE_INIT = 2'h1,
    MODE_RUN  = 2'h2
  } fpl_mode_t;

  // status display selection
  typedef enum logic [5:0] {
    DISP_OFF   = 6'h01,
    DISP_READY = 6'h02,
    DISP_DEGR  = 6'h04,
    DISP_NONC  = 6'h08,
    DISP_CRIT  = 6'h10,
    DISP_INIT  = 6'h20
  } fpl_disp_t;

  // identify led mode
  typedef enum logic [3:0] {
    ID_OFF     = 4'h1,
    ID_STEADY  = 4'h2,
    ID_TIMED   = 4'h4,
    ID_FOREVER = 4'h8
  } fpl_id_t;

endpackage : fpl_pkg

// >>> design/fpl_blink_if.sv
// blink timebase carried from the generator to its users
`timescale 1ns/1ps
interface fpl_blink_if;
  logic phase;   // current blink phase, high half on
  logic toggle;  // one cycle pulse in the cycle before phase flips
  modport src (output phase, output toggle);
  modport snk (input phase, input toggle);
endinterface : fpl_blink_if

// >>> design/fpl_blink.sv
// ~1 hz, 50 % duty blink timebase shared by all blinking leds
`timescale 1ns/1ps
module fpl_blink #(
  parameter int unsigned HALF_CYC = fpl_pkg::BLINK_HALF_CYC
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  fpl_blink_if.src   blink
);

  localparam int unsigned CW = $clog2(HALF_CYC) + 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } fpl_blink_st_t;

  fpl_blink_st_t st_r;
  fpl_blink_st_t st_nxt;
  logic          tgl;

  // equal on and off halves keep the duty at half
  assign tgl = (st_r.cnt == LAST);

  always_comb begin
    st_nxt = st_r;
    if (tgl) begin
      st_nxt.cnt   = '0;
      st_nxt.phase = ~st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign blink.phase  = st_r.phase;
  assign blink.toggle = tgl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_blink_flip_cause: assert property (
    1'b1 |=> ((st_r.phase != $past(st_r.phase)) == $past(tgl)))
    else $error("blink phase changed without its half period ending");

endmodule : fpl_blink

// >>> design/fpl_ident.sv
// blue identify led: button toggle and remote timed or endless blink
`timescale 1ns/1ps
module fpl_ident (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  fpl_blink_if.snk         blink,
  input  wire logic        id_btn,
  input  wire logic        cmd_timed,
  input  wire logic        cmd_forever,
  input  wire logic        cmd_off,
  output fpl_pkg::fpl_id_t id_mode,
  output logic             ident_blue
);

  typedef struct packed {
    fpl_pkg::fpl_id_t mode;
    logic             btn_q;
    logic [5:0]       cnt;
    logic             blue;
  } fpl_ident_st_t;

  fpl_ident_st_t st_r;
  fpl_ident_st_t st_nxt;
  logic          press;
  logic          any_cmd;

  assign press   = id_btn & ~st_r.btn_q;
  assign any_cmd = cmd_timed | cmd_forever | cmd_off;

  // remote commands win over a press in the same cycle
  always_comb begin
    st_nxt       = st_r;
    st_nxt.btn_q = id_btn;
    if (cmd_off) begin
      st_nxt.mode = fpl_pkg::ID_OFF;
    end else if (cmd_forever) begin
      st_nxt.mode = fpl_pkg::ID_FOREVER;
    end else if (cmd_timed) begin
      st_nxt.mode = fpl_pkg::ID_TIMED;
      st_nxt.cnt  = '0;
    end else if (press) begin
      // any lit state goes dark, dark goes steady blue
      if (st_r.mode == fpl_pkg::ID_OFF) begin
        st_nxt.mode = fpl_pkg::ID_STEADY;
      end else begin
        st_nxt.mode = fpl_pkg::ID_OFF;
      end
    end else if (st_r.mode == fpl_pkg::ID_TIMED && blink.toggle) begin
      if (st_r.cnt == fpl_pkg::IDENT_TOGGLES - 6'h1) begin
        st_nxt.mode = fpl_pkg::ID_OFF;
      end else begin
        st_nxt.cnt = st_r.cnt + 6'h1;
      end
    end
    case (st_nxt.mode)
      fpl_pkg::ID_STEADY:  st_nxt.blue = 1'b1;
      fpl_pkg::ID_TIMED:   st_nxt.blue = blink.phase;
      fpl_pkg::ID_FOREVER: st_nxt.blue = blink.phase;
      default:             st_nxt.blue = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{mode: fpl_pkg::ID_OFF, btn_q: 1'b0, cnt: 6'h0, blue: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign id_mode    = st_r.mode;
  assign ident_blue = st_r.blue;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_id_press_toggle: assert property (
    (press && !any_cmd && st_r.mode == fpl_pkg::ID_OFF)
    |=> (st_r.mode == fpl_pkg::ID_STEADY) && ident_blue)
    else $error("identify press from dark did not light steady blue");

  chk_id_timed_end: assert property (
    (st_r.mode == fpl_pkg::ID_TIMED && blink.toggle && !any_cmd && !press
     && st_r.cnt == fpl_pkg::IDENT_TOGGLES - 6'h1)
    |=> (st_r.mode == fpl_pkg::ID_OFF) && !ident_blue)
    else $error("timed identify did not end after its period");

endmodule : fpl_ident

// >>> design/fpl_top.sv
// front panel status, power button gate and identify led control
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - booted and ready with no fault shows steady green status.
// - degraded shows blinking green, incl. over ten errors with a spare used.
// - lost cpu, fan failure, lost redundancy and link errors are degraded.
// - non-critical faults such as critical voltage show blinking amber.
// - without sparing or mirroring, ten errors in the window blink amber.
// - fatal faults such as no good memory show steady amber.
// - uncorrectable error, cpu error, cpu missing, trips are also fatal.
// - after power up with standby present the status alternates amber and green during init.
// - power button presses are ignored while init is in progress.
// - init done ends the alternation and restores the power button.
// - each identify press in a cycle without a remote identify command toggles between steady blue and off.
// - a remote identify blinks blue for 15 s or until told to stop.
// - every blink runs near one hertz with equal on and off halves.
// - outside init, while amber is on or blinking the green status stays off.
module fpl_top #(
  parameter int unsigned BLINK_HALF_CYC = fpl_pkg::BLINK_HALF_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic [fpl_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  input  wire logic                         standby_supply_present,
  input  wire logic                         mgmt_init_done,
  input  wire logic [fpl_pkg::DEG_W-1:0]    degraded_in,
  input  wire logic [fpl_pkg::NONC_W-1:0]   noncrit_in,
  input  wire logic [fpl_pkg::FATAL_W-1:0]  fatal_in,
  input  wire logic                         pwr_btn,
  output logic                              pwr_btn_out,
  input  wire logic                         id_btn,
  output logic                              status_green,
  output logic                              status_amber,
  output logic                              ident_blue
);

  // whole state of the top level in one record
  typedef struct packed {
    fpl_pkg::fpl_mode_t mode;
    fpl_pkg::fpl_disp_t disp;
    logic               ready;
    logic               spare_mode;
    logic               mirror_mode;
    logic [3:0]         ce_cnt;
    logic               spare_used;
    logic               green;
    logic               amber;
    logic               pwr_out;
    logic [31:0]        rdata;
  } fpl_top_st_t;

  fpl_top_st_t      st_r;
  fpl_top_st_t      st_nxt;
  fpl_pkg::fpl_id_t id_mode;

  // register strobes decoded from the plain bus
  logic wr_ctrl;
  logic wr_mem;
  logic wr_ident;
  logic ce_event;
  logic ce_restart;
  logic spare_take;

  // health terms
  logic mem_degraded;
  logic mem_noncrit;
  logic any_fatal;
  logic any_noncrit;
  logic any_degraded;
  logic init_active;

  fpl_blink_if bl ();

  // shared timebase so every blinking led stays in step
  fpl_blink #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .clk     (clk),
    .sys_rst (sys_rst),
    .blink   (bl)
  );

  // write decode, address chain in priority order
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_mem   = 1'b0;
    wr_ident = 1'b0;
    if (reg_wr) begin
      if (reg_addr == fpl_pkg::ADDR_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (reg_addr == fpl_pkg::ADDR_MEM) begin
        wr_mem = 1'b1;
      end else if (reg_addr == fpl_pkg::ADDR_IDENT) begin
        wr_ident = 1'b1;
      end
    end
  end

  // memory event bits act as one cycle pulses, nothing is stored
  assign ce_event   = wr_mem & reg_wdata[fpl_pkg::MEM_CE_BIT];
  assign ce_restart = wr_mem & reg_wdata[fpl_pkg::MEM_RESTART_BIT];
  assign spare_take = wr_mem & reg_wdata[fpl_pkg::MEM_SPARE_BIT];

  fpl_ident u_ident (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .blink       (bl),
    .id_btn      (id_btn),
    .cmd_timed   (wr_ident & reg_wdata[fpl_pkg::ID_TIMED_BIT]),
    .cmd_forever (wr_ident & reg_wdata[fpl_pkg::ID_FOREVER_BIT]),
    .cmd_off     (wr_ident & reg_wdata[fpl_pkg::ID_OFF_BIT]),
    .id_mode     (id_mode),
    .ident_blue  (ident_blue)
  );

  // sparing needs more than the limit and a spare in use
  assign mem_degraded = st_r.spare_mode & st_r.spare_used
                      & (st_r.ce_cnt > fpl_pkg::CE_LIMIT);
  // plain memory hits the limit within the software window
  assign mem_noncrit  = ~st_r.spare_mode & ~st_r.mirror_mode
                      & (st_r.ce_cnt >= fpl_pkg::CE_LIMIT);

  assign any_fatal    = |fatal_in;
  assign any_noncrit  = (|noncrit_in) | mem_noncrit;
  assign any_degraded = (|degraded_in) | mem_degraded;
  assign init_active  = (st_r.mode == fpl_pkg::MODE_INIT);

  // next state: registers, counters, mode, display and bus answer
  always_comb begin
    st_nxt = st_r;

    // software written configuration
    if (wr_ctrl) begin
      st_nxt.ready       = reg_wdata[fpl_pkg::CTRL_READY_BIT];
      st_nxt.spare_mode  = reg_wdata[fpl_pkg::CTRL_SPARE_BIT];
      st_nxt.mirror_mode = reg_wdata[fpl_pkg::CTRL_MIRROR_BIT];
    end

    // restart clears first so an error in the same write still counts
    if (ce_restart) begin
      st_nxt.ce_cnt     = '0;
      st_nxt.spare_used = 1'b0;
    end
    if (ce_event && st_nxt.ce_cnt != fpl_pkg::CE_MAX) begin
      st_nxt.ce_cnt = st_nxt.ce_cnt + 4'h1;
    end
    if (spare_take) begin
      st_nxt.spare_used = 1'b1;
    end

    // controller init holds until the controller reports done
    case (st_r.mode)
      fpl_pkg::MODE_INIT: begin
        if (mgmt_init_done) begin
          st_nxt.mode = fpl_pkg::MODE_RUN;
        end
      end
      fpl_pkg::MODE_RUN: begin
        st_nxt.mode = fpl_pkg::MODE_RUN;
      end
      default: begin
        st_nxt.mode = fpl_pkg::MODE_INIT;
      end
    endcase

    // severity order, worst condition first
    if (init_active) begin
      if (standby_supply_present) begin
        st_nxt.disp = fpl_pkg::DISP_INIT;
      end else begin
        st_nxt.disp = fpl_pkg::DISP_OFF;
      end
    end else if (any_fatal) begin
      st_nxt.disp = fpl_pkg::DISP_CRIT;
    end else if (any_noncrit) begin
      st_nxt.disp = fpl_pkg::DISP_NONC;
    end else if (any_degraded) begin
      st_nxt.disp = fpl_pkg::DISP_DEGR;
    end else if (st_r.ready) begin
      st_nxt.disp = fpl_pkg::DISP_READY;
    end else begin
      st_nxt.disp = fpl_pkg::DISP_OFF;
    end

    // colour per display; amber states never light green
    case (st_nxt.disp)
      fpl_pkg::DISP_INIT: begin
        st_nxt.green = bl.phase;
        st_nxt.amber = ~bl.phase;
      end
      fpl_pkg::DISP_CRIT: begin
        st_nxt.green = 1'b0;
        st_nxt.amber = 1'b1;
      end
      fpl_pkg::DISP_NONC: begin
        st_nxt.green = 1'b0;
        st_nxt.amber = bl.phase;
      end
      fpl_pkg::DISP_DEGR: begin
        st_nxt.green = bl.phase;
        st_nxt.amber = 1'b0;
      end
      fpl_pkg::DISP_READY: begin
        st_nxt.green = 1'b1;
        st_nxt.amber = 1'b0;
      end
      default: begin
        st_nxt.green = 1'b0;
        st_nxt.amber = 1'b0;
      end
    endcase

    // the button reaches the system only once init is over
    st_nxt.pwr_out = pwr_btn & (st_nxt.mode == fpl_pkg::MODE_RUN);

    // read answer stands for exactly the cycle after the strobe
    st_nxt.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == fpl_pkg::ADDR_CTRL) begin
        st_nxt.rdata[fpl_pkg::CTRL_READY_BIT]  = st_r.ready;
        st_nxt.rdata[fpl_pkg::CTRL_SPARE_BIT]  = st_r.spare_mode;
        st_nxt.rdata[fpl_pkg::CTRL_MIRROR_BIT] = st_r.mirror_mode;
      end else if (reg_addr == fpl_pkg::ADDR_MEM) begin
        st_nxt.rdata[fpl_pkg::MEM_SPARE_BIT] = st_r.spare_used;
        st_nxt.rdata[fpl_pkg::MEM_CNT_LSB +: 4] = st_r.ce_cnt;
      end else if (reg_addr == fpl_pkg::ADDR_IDENT) begin
        st_nxt.rdata[3:0] = id_mode;
      end else if (reg_addr == fpl_pkg::ADDR_STATUS) begin
        st_nxt.rdata = {16'h0, st_r.disp, init_active, ident_blue,
                        st_r.amber, st_r.green, st_r.mode,
                        st_r.pwr_out, 3'h0};
      end
    end
  end

  // async reset lands in init: power has just been applied
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{mode:        fpl_pkg::MODE_INIT,
                disp:        fpl_pkg::DISP_OFF,
                ready:       1'b0,
                spare_mode:  1'b0,
                mirror_mode: 1'b0,
                ce_cnt:      4'h0,
                spare_used:  1'b0,
                green:       1'b0,
                amber:       1'b0,
                pwr_out:     1'b0,
                rdata:       32'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata    = st_r.rdata;
  assign pwr_btn_out  = st_r.pwr_out;
  assign status_green = st_r.green;
  assign status_amber = st_r.amber;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_amber_excl_green: assert property (
    !(status_amber && status_green))
    else $error("green status lit together with amber");

  chk_fatal_steady_amber: assert property (
    (!init_active && any_fatal) [*2] |=> status_amber [*1])
    else $error("fatal condition did not show steady amber");

  chk_fatal_outranks: assert property (
    (!init_active && any_fatal && any_noncrit)
    |=> (st_r.disp == fpl_pkg::DISP_CRIT) && !status_green)
    else $error("fatal condition lost to a lesser one");

  chk_nonc_blink_amber: assert property (
    (!init_active && !any_fatal && |noncrit_in)
    |=> (status_amber == $past(bl.phase)) && !status_green)
    else $error("non-critical fault not blinking amber");

  chk_ce_window_amber: assert property (
    (!init_active && !any_fatal && !st_r.spare_mode && !st_r.mirror_mode
     && st_r.ce_cnt >= fpl_pkg::CE_LIMIT)
    |=> st_r.disp == fpl_pkg::DISP_NONC)
    else $error("error count limit did not raise non-critical");

  chk_degr_blink_green: assert property (
    (!init_active && !any_fatal && !any_noncrit && |degraded_in)
    |=> (status_green == $past(bl.phase)) && !status_amber)
    else $error("degraded condition not blinking green");

  chk_ready_steady: assert property (
    (!init_active && !any_fatal && !any_noncrit && !any_degraded
     && st_r.ready) |=> status_green && !status_amber)
    else $error("ready system not steady green");

  chk_init_alternate: assert property (
    (init_active && standby_supply_present && !mgmt_init_done)
    |=> (status_green != status_amber))
    else $error("init pattern not alternating");

  chk_pwr_blocked: assert property (
    (init_active && !mgmt_init_done) |=> !pwr_btn_out)
    else $error("power button passed during init");

  chk_pwr_restored: assert property (
    (init_active && mgmt_init_done) ##1 pwr_btn |=> pwr_btn_out)
    else $error("power button not restored after init");

  // a slide back into init would lock the power button again
  chk_run_mode_kept: assert property (
    (st_r.mode == fpl_pkg::MODE_RUN) |=> (st_r.mode == fpl_pkg::MODE_RUN))
    else $error("block fell back into init while running");

  chk_mem_degr_green: assert property (
    (!init_active && !any_fatal && !any_noncrit && mem_degraded)
    |=> (st_r.disp == fpl_pkg::DISP_DEGR) && !status_amber)
    else $error("spare memory over the error limit not degraded");

  chk_nonc_outranks: assert property (
    (!init_active && !any_fatal && any_noncrit && any_degraded)
    |=> (st_r.disp == fpl_pkg::DISP_NONC) && !status_green)
    else $error("non-critical condition lost to degraded");

  cov_init_to_run: cover property (
    init_active && mgmt_init_done ##1 !init_active);

  cov_critical_shown: cover property (
    st_r.disp == fpl_pkg::DISP_CRIT);

  cov_ce_limit: cover property (
    ce_event && st_r.ce_cnt == fpl_pkg::CE_LIMIT - 4'h1);

  cov_ident_timed: cover property (
    id_mode == fpl_pkg::ID_TIMED ##1 id_mode == fpl_pkg::ID_OFF);

  cov_mirror_limit: cover property (
    st_r.mirror_mode && st_r.ce_cnt >= fpl_pkg::CE_LIMIT);

endmodule : fpl_top

// >>> dv/fpl_mgmt_model.sv
// management controller and front panel button model
`timescale 1ns/1ps
module fpl_mgmt_model (
  input  wire logic                        clk,
  output logic                             standby_supply_present,
  output logic                             mgmt_init_done,
  output logic [fpl_pkg::DEG_W-1:0]        degraded_in,
  output logic [fpl_pkg::NONC_W-1:0]       noncrit_in,
  output logic [fpl_pkg::FATAL_W-1:0]      fatal_in,
  output logic                             pwr_btn,
  output logic                             id_btn
);
  // ac applied with standby present, controller still busy
  initial begin
    standby_supply_present = 1'b1;
    mgmt_init_done         = 1'b0;
    degraded_in            = '0;
    noncrit_in             = '0;
    fatal_in               = '0;
    pwr_btn                = 1'b0;
    id_btn                 = 1'b0;
  end

  // health levels, wide arguments sliced to the port widths
  task automatic set_health(input logic [31:0] d, n, f);
    @(posedge clk);
    degraded_in <= d[fpl_pkg::DEG_W-1:0];
    noncrit_in  <= n[fpl_pkg::NONC_W-1:0];
    fatal_in    <= f[fpl_pkg::FATAL_W-1:0];
  endtask : set_health

  // button levels; an identify press is its rising edge
  task automatic set_btn(input logic p, i);
    @(posedge clk);
    pwr_btn <= p;
    id_btn  <= i;
  endtask : set_btn

  // controller finishes after a chosen delay, prompt or slow
  task automatic finish_init(input int dly);
    repeat (dly) @(posedge clk);
    mgmt_init_done <= 1'b1;
  endtask : finish_init
endmodule : fpl_mgmt_model

// >>> dv/fpl_top_bench.sv
// self-checking bench for the front panel status led logic
`timescale 1ns/1ps
module fpl_top_bench;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        sb, idone, pb, pb_out, ib, grn, amb, blu;
  logic [6:0]  deg;
  logic [2:0]  nonc;
  logic [7:0]  fat;
  logic [31:0] v;
  int          fail_count, compares, cyc, g, a, b, s;

  fpl_mgmt_model mgmt (.clk(clk), .standby_supply_present(sb),
    .mgmt_init_done(idone), .degraded_in(deg), .noncrit_in(nonc),
    .fatal_in(fat), .pwr_btn(pb), .id_btn(ib));

  // short blink half period keeps the timed identify at 120 cycles
  fpl_top #(.BLINK_HALF_CYC(4)) dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_supply_present(sb),
    .mgmt_init_done(idone), .degraded_in(deg), .noncrit_in(nonc),
    .fatal_in(fat), .pwr_btn(pb), .pwr_btn_out(pb_out), .id_btn(ib),
    .status_green(grn), .status_amber(amb), .ident_blue(blu));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // hang guard, the sequence needs about 870 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic disp(input logic [5:0] e);
    rd(fpl_pkg::ADDR_STATUS, v);
    check("display", {26'h0, e}, {26'h0, v[15:10]});
  endtask : disp

  // 16 cycles span two blink periods: a blinking led is high 8 of them
  task automatic watch();
    g = 0; a = 0; b = 0; s = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      g += int'(grn === 1'b1);
      a += int'(amb === 1'b1);
      b += int'(blu === 1'b1);
      s += int'(grn === amb);
    end
  endtask : watch

  task automatic leds(input int eg, ea);
    repeat (3) @(posedge clk);
    watch();
    check("green count", eg, g);
    check("amber count", ea, a);
  endtask : leds

  task automatic test_end(input string n);
    $display("test %s done", n);
  endtask : test_end

  initial begin
    sys_rst = 1'b1; reg_addr = '0; reg_wdata = '0;
    reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    mgmt.set_btn(1'b1, 1'b0);
    leds(8, 8);
    check("alternation", 0, s);
    check("pwr gated", 0, pb_out);
    disp(fpl_pkg::DISP_INIT);
    mgmt.finish_init(5);
    repeat (4) @(posedge clk);
    #1 check("pwr restored", 1, pb_out);
    mgmt.set_btn(1'b0, 1'b0);
    leds(0, 0);
    test_end("init");
    wr(fpl_pkg::ADDR_CTRL, 32'h1);
    leds(16, 0);
    rd(8'hf0, v);
    check("unmapped read", 0, v);
    test_end("ready");
    for (int i = 0; i < fpl_pkg::DEG_W; i++) begin
      mgmt.set_health(32'h1 << i, 0, 0);
      leds(8, 0);
    end
    for (int i = 0; i < fpl_pkg::NONC_W; i++) begin
      mgmt.set_health(0, 32'h1 << i, 0);
      leds(0, 8);
    end
    for (int i = 0; i < fpl_pkg::FATAL_W; i++) begin
      mgmt.set_health(32'h7f, 0, 32'h1 << i);
      leds(0, 16);
    end
    mgmt.set_health(32'h7f, 32'h7, 32'hff);
    disp(fpl_pkg::DISP_CRIT);
    mgmt.set_health(32'h7f, 32'h7, 0);
    disp(fpl_pkg::DISP_NONC);
    mgmt.set_health(0, 0, 0);
    test_end("health");
    repeat (9) wr(fpl_pkg::ADDR_MEM, 32'h1);
    disp(fpl_pkg::DISP_READY);
    wr(fpl_pkg::ADDR_MEM, 32'h1);
    disp(fpl_pkg::DISP_NONC);
    rd(fpl_pkg::ADDR_MEM, v);
    check("error count", 10, {28'h0, v[7:4]});
    wr(fpl_pkg::ADDR_MEM, 32'h2);
    wr(fpl_pkg::ADDR_CTRL, 32'h3);
    wr(fpl_pkg::ADDR_MEM, 32'h4);
    repeat (10) wr(fpl_pkg::ADDR_MEM, 32'h1);
    disp(fpl_pkg::DISP_READY);
    wr(fpl_pkg::ADDR_MEM, 32'h1);
    disp(fpl_pkg::DISP_DEGR);
    wr(fpl_pkg::ADDR_MEM, 32'h2);
    wr(fpl_pkg::ADDR_CTRL, 32'h5);
    repeat (10) wr(fpl_pkg::ADDR_MEM, 32'h1);
    disp(fpl_pkg::DISP_READY);
    wr(fpl_pkg::ADDR_CTRL, 32'h1);
    disp(fpl_pkg::DISP_NONC);
    wr(fpl_pkg::ADDR_MEM, 32'h2);
    test_end("memory");
    for (int i = 1; i >= 0; i--) begin
      mgmt.set_btn(1'b0, 1'b1);
      mgmt.set_btn(1'b0, 1'b0);
      repeat (3) @(posedge clk);
      #1 check("blue by button", i, blu);
      rd(fpl_pkg::ADDR_IDENT, v);
      check("ident mode", i ? 2 : 1, v[3:0]);
    end
    // remote identify requests issued on the far side's behalf
    wr(fpl_pkg::ADDR_IDENT, 32'h1);
    repeat (3) @(posedge clk);
    watch();
    check("timed blue count", 8, b);
    repeat (80) @(posedge clk);
    rd(fpl_pkg::ADDR_IDENT, v);
    check("timed running", 4, v[3:0]);
    repeat (40) @(posedge clk);
    rd(fpl_pkg::ADDR_IDENT, v);
    check("timed expired", 1, v[3:0]);
    check("blue after timed", 0, blu);
    wr(fpl_pkg::ADDR_IDENT, 32'h2);
    repeat (150) @(posedge clk);
    rd(fpl_pkg::ADDR_IDENT, v);
    check("endless running", 8, v[3:0]);
    wr(fpl_pkg::ADDR_IDENT, 32'h4);
    rd(fpl_pkg::ADDR_IDENT, v);
    check("endless stopped", 1, v[3:0]);
    test_end("identify");
    final_report();
  end
endmodule : fpl_top_bench
